//--- core/ssnl_pkg.sv
package ssnl_pkg;
	// Non-volatile store layout
	localparam int NVM_WORDS      = 32;
	localparam int WORD_W         = 16;
	localparam int ADDR_W         = 5;
	localparam int FIELD_W        = 5;
	localparam int LOCK_BIT       = 15;
	localparam logic [4:0] REDUND_WORDS  = 5'h1D;
	localparam logic [4:0] LAST_ADDR     = 5'h1F;
	localparam logic [4:0] TRACE_ID_ADDR = 5'h1E;
	// Word addresses of loaded settings
	localparam logic [4:0] ADDR_OSC_TRIM  = 5'h00;
	localparam logic [4:0] ADDR_BAL_TRIM  = 5'h01;
	localparam logic [4:0] ADDR_IREF_TRIM = 5'h02;
	localparam logic [4:0] ADDR_PLATE     = 5'h03;
	localparam logic [4:0] ADDR_TC1_LO    = 5'h04;
	localparam logic [4:0] ADDR_TC1_HI    = 5'h05;
	localparam logic [4:0] ADDR_OPTIONS   = 5'h06;
	localparam logic [4:0] ADDR_CRC_LO    = 5'h1B;
	localparam logic [4:0] ADDR_CRC_HI    = 5'h1C;
	// Field positions in the options word
	localparam int OPT_CLIP_EN_BIT   = 0;
	localparam int OPT_FAULT_SIDE_BIT = 1;
	// Integrity check
	localparam int CRC_W = 10;
	localparam logic [9:0] CRC_POLY = 10'h233;
	localparam logic [9:0] CRC_INIT = 10'h000;
	// Diagnostic counts
	localparam int CLIP_COUNT_LIMIT = 4;
	localparam int CRC_FAIL_LIMIT   = 3;
	// Converter and output codes
	localparam int CODE_W = 12;
	localparam logic [11:0] CONV_MAX_CODE = 12'hFFF;
	localparam logic [11:0] CONV_MIN_CODE = 12'h000;
	localparam logic [11:0] LOW_SAT_CODE  = 12'h0040;
	localparam logic [11:0] HIGH_SAT_CODE = 12'h0FC0;

	typedef enum logic [4:0] {
		S_LOAD    = 5'b00001,
		S_RUN     = 5'b00010,
		S_PROG    = 5'b00100,
		S_PROG_AC = 5'b01000,
		S_OVER    = 5'b10000
	} ssnl_state_e;
endpackage

//--- core/ssnl_nvm_store.sv
`timescale 1ns/10ps
`default_nettype none
module ssnl_nvm_store #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 16,
	parameter int AW    = 5
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// Write port
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// Read port, data one cycle after the request
	input  wire logic             re_i,
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);
	typedef struct packed {
		logic [WIDTH-1:0] rdata;
	} ssnl_mem_s;

	ssnl_mem_s                    s_q;
	ssnl_mem_s                    s_d;
	logic [DEPTH-1:0][WIDTH-1:0]  cells;

	initial begin
		if (DEPTH != (1 << AW)) begin
			$error("Depth must equal two to the address width");
		end
	end

	always_comb begin
		s_d = s_q;
		if (re_i) begin
			s_d.rdata = cells[raddr_i];
		end
	end

	// Cells keep their content through reset, as a non-volatile array would
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			cells[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
endmodule
`default_nettype wire

//--- core/ssnl_loader.sv
// Notes on behaviour
// - Clip fault only when clip enable is set
// - Clip fault after four successive clipped conversions
// - Without enable, clipping saturates to max or min
// - Temperature conversions never count toward clipping
// - Fault side picks low or high saturation
// - CRC fault after three failed checks
// - CRC10 over voted fields, LSB first, per address
// - Below reset level, all but the stored words reset, output off
// - After reset, load every setting before running
// - Measurement runs only above undervoltage level
// - Undervoltage turns the output driver off
// - Startup only after reset, not undervoltage recovery
// - Programming level: output off, answer commands only
// - Overvoltage disconnects; full reset on return
// - Reset acts at once, no filtering
// - Store holds 32 words of 16 bits
// - First 29 words voted two of three
// - Lock bit 15 plus three 5-bit copies
// - Locked word refuses programming writes
// - Last three words read without voting
// - Trace identifier words never writable
// - Reads allowed regardless of lock
// - Oscillator trim is a 5-bit field
`timescale 1ns/10ps
`default_nettype none
module ssnl_loader #(
	parameter int CLIP_LIMIT = ssnl_pkg::CLIP_COUNT_LIMIT,
	parameter int CRC_LIMIT  = ssnl_pkg::CRC_FAIL_LIMIT
) (
	// Clock and power-on reset
	input  wire logic                           clk_i,
	input  wire logic                           rstn_i,
	// Supply detectors, asynchronous levels
	input  wire logic                           uv_ok_i,
	input  wire logic                           prog_level_i,
	input  wire logic                           overvoltage_i,
	// Converter results
	input  wire logic                           conv_valid_i,
	input  wire logic                           conv_is_temp_i,
	input  wire logic                           conv_over_i,
	input  wire logic                           conv_under_i,
	input  wire logic [ssnl_pkg::CODE_W-1:0]    conv_code_i,
	// Output driver
	output logic      [ssnl_pkg::CODE_W-1:0]    out_code_o,
	output logic                                out_update_o,
	output logic                                out_drive_o,
	// Programming link commands
	input  wire logic                           prog_rd_i,
	input  wire logic                           prog_wr_i,
	input  wire logic [ssnl_pkg::ADDR_W-1:0]    prog_addr_i,
	input  wire logic [ssnl_pkg::WORD_W-1:0]    prog_wdata_i,
	output logic      [ssnl_pkg::WORD_W-1:0]    prog_rdata_o,
	output logic                                prog_ack_o,
	output logic                                prog_refused_o,
	// Loaded settings and status
	output logic      [4:0]                     oscillator_trim_o,
	output logic      [4:0]                     current_source_balance_trim_o,
	output logic      [2:0]                     reference_current_trim_o,
	output logic      [3:0]                     plate_current_setting_o,
	output logic      [6:0]                     first_order_temp_comp_o,
	output logic                                running_o,
	output logic                                programming_mode_o,
	output logic                                crc_fault_level_o,
	output logic                                clip_fault_level_o
);
	import ssnl_pkg::*;

	localparam logic [2:0] CLIP_LIM = 3'(CLIP_LIMIT);
	localparam logic [1:0] CRC_LIM  = 2'(CRC_LIMIT);

	typedef struct packed {
		ssnl_state_e       st;
		logic [4:0]        addr;
		logic              iss_done;
		logic              pend;
		logic [4:0]        paddr;
		logic [9:0]        crc;
		logic [9:0]        crc_ref;
		logic [1:0]        fails;
		logic              crc_fault;
		logic [2:0]        clip_cnt;
		logic [4:0]        osc;
		logic [4:0]        bal;
		logic [2:0]        iref;
		logic [3:0]        plate;
		logic [6:0]        tc1;
		logic [1:0]        opt;
		logic [11:0]       out_code;
		logic              upd;
		logic              seen;
		logic [1:0]        uv_s;
		logic [1:0]        prog_s;
		logic [1:0]        ov_s;
		logic              p_wr;
		logic [4:0]        p_addr;
		logic [15:0]       p_wdata;
		logic [15:0]       p_rdata;
		logic              p_ack;
		logic              p_ref;
	} ssnl_regs_s;

	localparam ssnl_regs_s RST_S = '{st: S_LOAD, crc: CRC_INIT, default: '0};

	ssnl_regs_s        s_q;
	ssnl_regs_s        s_d;
	logic              mem_we;
	logic              mem_re;
	logic [4:0]        mem_raddr;
	logic [15:0]       mem_rdata;
	logic [4:0]        voted;
	logic              uv_ok;
	logic              prog_now;
	logic              ov_now;
	logic              clip_en;
	logic              side_hi;
	logic [11:0]       fault_code;
	logic              clip_hit;
	logic [11:0]       conv_sat;
	logic [2:0]        cnt_next;

	initial begin
		if (CLIP_LIMIT < 1 || CLIP_LIMIT > 7 || CRC_LIMIT < 1 || CRC_LIMIT > 3) begin
			$error("Diagnostic limits out of range");
		end
	end

	// Shift the voted field in LSB first
	function automatic logic [9:0] crc_step(input logic [9:0] c, input logic [4:0] d);
		logic [9:0] r;
		logic       fb;
		r = c;
		for (int i = 0; i < FIELD_W; i++) begin
			fb = r[9] ^ d[i];
			r  = {r[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
		end
		return r;
	endfunction

	ssnl_nvm_store #(
		.DEPTH (NVM_WORDS),
		.WIDTH (WORD_W),
		.AW    (ADDR_W)
	) u_store (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.we_i    (mem_we),
		.waddr_i (s_q.p_addr),
		.wdata_i (s_q.p_wdata),
		.re_i    (mem_re),
		.raddr_i (mem_raddr),
		.rdata_o (mem_rdata)
	);

	genvar b;
	generate
		for (b = 0; b < FIELD_W; b++) begin : g_vote
			assign voted[b] = (mem_rdata[b] & mem_rdata[b+5]) |
				(mem_rdata[b] & mem_rdata[b+10]) |
				(mem_rdata[b+5] & mem_rdata[b+10]);
		end
	endgenerate

	// Only the second stage of each synchroniser is read
	assign uv_ok      = s_q.uv_s[1];
	assign prog_now   = s_q.prog_s[1];
	assign ov_now     = s_q.ov_s[1];
	assign clip_en    = s_q.opt[OPT_CLIP_EN_BIT];
	assign side_hi    = s_q.opt[OPT_FAULT_SIDE_BIT];
	assign fault_code = side_hi ? HIGH_SAT_CODE : LOW_SAT_CODE;
	assign clip_hit   = conv_over_i | conv_under_i;
	assign conv_sat   = conv_over_i ? CONV_MAX_CODE :
		(conv_under_i ? CONV_MIN_CODE : conv_code_i);
	assign cnt_next   = !clip_hit ? 3'h0 :
		((s_q.clip_cnt < CLIP_LIM) ? s_q.clip_cnt + 3'h1 : s_q.clip_cnt);

	always_comb begin
		s_d        = s_q;
		s_d.upd    = 1'b0;
		s_d.p_ack  = 1'b0;
		s_d.p_ref  = 1'b0;
		mem_we     = 1'b0;
		mem_re     = 1'b0;
		mem_raddr  = s_q.addr;
		case (s_q.st)
			S_LOAD: begin
				s_d.pend = 1'b0;
				if (!s_q.iss_done) begin
					mem_re       = 1'b1;
					s_d.pend     = 1'b1;
					s_d.paddr    = s_q.addr;
					s_d.addr     = s_q.addr + 5'h1;
					s_d.iss_done = (s_q.addr == LAST_ADDR);
				end
				if (s_q.pend) begin
					if (s_q.paddr < ADDR_CRC_LO) begin
						s_d.crc = crc_step(s_q.crc, voted);
					end
					case (s_q.paddr)
						ADDR_OSC_TRIM:  s_d.osc = voted;
						ADDR_BAL_TRIM:  s_d.bal = voted;
						ADDR_IREF_TRIM: s_d.iref = voted[2:0];
						ADDR_PLATE:     s_d.plate = voted[3:0];
						ADDR_TC1_LO:    s_d.tc1[4:0] = voted;
						ADDR_TC1_HI:    s_d.tc1[6:5] = voted[1:0];
						ADDR_OPTIONS:   s_d.opt = voted[1:0];
						ADDR_CRC_LO:    s_d.crc_ref[4:0] = voted;
						ADDR_CRC_HI:    s_d.crc_ref[9:5] = voted;
						default: begin
						end
					endcase
					// Identification words are read raw and take no part in the check
					if (s_q.paddr == LAST_ADDR) begin
						if (s_q.crc == s_q.crc_ref) begin
							s_d.st = S_RUN;
						end else if (s_q.fails + 2'h1 >= CRC_LIM) begin
							s_d.fails     = s_q.fails + 2'h1;
							s_d.crc_fault = 1'b1;
							s_d.st        = S_RUN;
						end else begin
							s_d.fails    = s_q.fails + 2'h1;
							s_d.addr     = 5'h00;
							s_d.iss_done = 1'b0;
							s_d.crc      = CRC_INIT;
						end
					end
				end
			end
			S_RUN: begin
				if (uv_ok && conv_valid_i && !conv_is_temp_i) begin
					s_d.clip_cnt = cnt_next;
					s_d.upd      = 1'b1;
					s_d.seen     = 1'b1;
					if (s_q.crc_fault || (clip_en && cnt_next >= CLIP_LIM)) begin
						s_d.out_code = fault_code;
					end else begin
						s_d.out_code = conv_sat;
					end
				end else if (s_q.crc_fault) begin
					s_d.out_code = fault_code;
				end
			end
			S_PROG: begin
				if (prog_rd_i || prog_wr_i) begin
					mem_re      = 1'b1;
					mem_raddr   = prog_addr_i;
					s_d.p_wr    = prog_wr_i;
					s_d.p_addr  = prog_addr_i;
					s_d.p_wdata = prog_wdata_i;
					s_d.st      = S_PROG_AC;
				end
			end
			S_PROG_AC: begin
				s_d.st = S_PROG;
				if (!s_q.p_wr) begin
					s_d.p_rdata = mem_rdata;
					s_d.p_ack   = 1'b1;
				end else if (s_q.p_addr >= TRACE_ID_ADDR ||
					(s_q.p_addr < REDUND_WORDS && mem_rdata[LOCK_BIT])) begin
					s_d.p_ref = 1'b1;
				end else begin
					mem_we    = 1'b1;
					s_d.p_ack = 1'b1;
				end
			end
			S_OVER: begin
				// Leaving overvoltage restarts from a clean reset state
				if (!ov_now) begin
					s_d = RST_S;
				end
			end
			default: begin
				s_d = RST_S;
			end
		endcase
		if (ov_now) begin
			s_d.st = S_OVER;
		end else if (prog_now && (s_q.st == S_LOAD || s_q.st == S_RUN)) begin
			s_d.st = S_PROG;
		end else if (!prog_now && (s_q.st == S_PROG)) begin
			s_d = RST_S;
		end
		s_d.uv_s   = {s_q.uv_s[0], uv_ok_i};
		s_d.prog_s = {s_q.prog_s[0], prog_level_i};
		s_d.ov_s   = {s_q.ov_s[0], overvoltage_i};
	end

	// Reset is the supply monitor itself: unfiltered and asynchronous
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= RST_S;
		end else begin
			s_q <= s_d;
		end
	end

	assign out_code_o                    = s_q.out_code;
	assign out_update_o                  = s_q.upd;
	assign out_drive_o                   = (s_q.st == S_RUN) && s_q.seen && uv_ok &&
		!prog_now && !ov_now;
	assign prog_rdata_o                  = s_q.p_rdata;
	assign prog_ack_o                    = s_q.p_ack;
	assign prog_refused_o                = s_q.p_ref;
	assign oscillator_trim_o             = s_q.osc;
	assign current_source_balance_trim_o = s_q.bal;
	assign reference_current_trim_o      = s_q.iref;
	assign plate_current_setting_o       = s_q.plate;
	assign first_order_temp_comp_o       = s_q.tc1;
	assign running_o                     = (s_q.st == S_RUN);
	assign programming_mode_o            = (s_q.st == S_PROG) || (s_q.st == S_PROG_AC);
	assign crc_fault_level_o             = s_q.crc_fault;
	assign clip_fault_level_o            = running_o && clip_en && (s_q.clip_cnt >= CLIP_LIM);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_main_conv;
		running_o && uv_ok && conv_valid_i && !conv_is_temp_i;
	endsequence
	sequence s_locked_write;
		s_q.st == S_PROG_AC && s_q.p_wr && s_q.p_addr < REDUND_WORDS && mem_rdata[LOCK_BIT];
	endsequence

	property p_clip_needs_enable;
		clip_fault_level_o |-> clip_en && s_q.clip_cnt >= CLIP_LIM;
	endproperty
	a_clip_needs_enable: assert property (p_clip_needs_enable) else $error("Clip fault without cause");

	property p_saturate;
		s_main_conv ##0 (conv_over_i && !clip_en && !s_q.crc_fault) |=> out_code_o == CONV_MAX_CODE && out_update_o;
	endproperty
	a_saturate: assert property (p_saturate) else $error("Overrange not saturated high");

	property p_temp_ignored;
		running_o && conv_valid_i && conv_is_temp_i |=> $stable(s_q.clip_cnt) && !out_update_o;
	endproperty
	a_temp_ignored: assert property (p_temp_ignored) else $error("Temperature clip counted");

	property p_fault_side;
		running_o && s_q.crc_fault && !ov_now && !prog_now |=> out_code_o == (side_hi ? HIGH_SAT_CODE : LOW_SAT_CODE);
	endproperty
	a_fault_side: assert property (p_fault_side) else $error("Fault output on wrong side");

	property p_crc_after_fails;
		$rose(crc_fault_level_o) |-> s_q.fails == 2'd3 && $past(s_q.fails) == 2'd2;
	endproperty
	a_crc_after_fails: assert property (p_crc_after_fails) else $error("CRC fault at wrong count");

	property p_uv_off;
		!uv_ok || prog_now || ov_now |-> !out_drive_o;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("Driver on outside normal supply");

	property p_lock_refuse;
		s_locked_write |-> !mem_we ##1 prog_refused_o && !prog_ack_o;
	endproperty
	a_lock_refuse: assert property (p_lock_refuse) else $error("Locked word written");

	property p_clip_clear;
		s_main_conv ##0 !clip_hit && !ov_now && !prog_now |=> s_q.clip_cnt == 3'd0;
	endproperty
	a_clip_clear: assert property (p_clip_clear) else $error("Clip count not cleared");

	property p_read_answers;
		s_q.st == S_PROG && prog_rd_i && !prog_wr_i && prog_now && !ov_now |=> ##1 prog_ack_o && !prog_refused_o;
	endproperty
	a_read_answers: assert property (p_read_answers) else $error("Read not answered");
endmodule
`default_nettype wire

//--- tb/ssnl_prog_unit.sv
`timescale 1ns/10ps
`default_nettype none
module ssnl_prog_unit (
	// Clock
	input  wire logic        clk_i,
	// Answers from the device
	input  wire logic        ack_i,
	input  wire logic        refused_i,
	input  wire logic [15:0] rdata_i,
	// Commands to the device
	output logic             rd_o,
	output logic             wr_o,
	output logic [4:0]       addr_o,
	output logic [15:0]      wdata_o
);
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 5'h00;
		wdata_o = 16'h0000;
	end
	// One strobe, then silence until the answer comes back
	task automatic cmd(input logic wr, input logic [4:0] a, input logic [15:0] d,
			output logic [15:0] rd, output logic rf, output logic ok);
		ok = 1'b0;
		rf = 1'b0;
		rd = 16'h0000;
		@(posedge clk_i);
		rd_o <= ~wr;
		wr_o <= wr;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		rd_o <= 1'b0;
		wr_o <= 1'b0;
		// Released lines must not keep showing the last value
		addr_o <= ~a;
		wdata_o <= ~d;
		for (int i = 0; i < 6 && !ok; i++) begin
			@(posedge clk_i);
			#1;
			if (ack_i === 1'b1 || refused_i === 1'b1) begin
				ok = 1'b1;
				rf = refused_i;
				rd = rdata_i;
			end
		end
	endtask
endmodule
`default_nettype wire

//--- tb/sensor_supervisor_nvm_loader_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_supervisor_nvm_loader_bench;
	import ssnl_pkg::*;
	typedef struct packed {
		logic        temp;
		logic        over;
		logic        under;
		logic [11:0] code;
		logic        upd;
		logic [11:0] exp;
		logic        fault;
	} ssnl_row_s;
	logic clk, rstn, uv, plev, ov, cv, ct, co, cu, od, ou, prd, pwr, pack, pref;
	logic run, pm, crcf, clipf;
	logic [11:0] cc, oc;
	logic [4:0]  pa, t_osc, t_bal;
	logic [15:0] pwd, prdat;
	logic [2:0]  t_ref;
	logic [3:0]  t_pl;
	logic [6:0]  t_tc;
	logic [4:0]  fld [29];
	int fail_count = 0;
	int samples_checked = 0;
	// Clip run with a temperature result inside it, then a clean clear
	ssnl_row_s rows [8] = '{
		'{0, 0, 0, 12'h123, 1, 12'h123, 0},
		'{0, 1, 0, 12'h800, 1, 12'hFFF, 0},
		'{0, 1, 0, 12'h800, 1, 12'hFFF, 0},
		'{0, 1, 0, 12'h800, 1, 12'hFFF, 0},
		'{1, 1, 0, 12'h800, 0, 12'h000, 0},
		'{0, 1, 0, 12'h800, 1, 12'h040, 1},
		'{0, 0, 0, 12'h456, 1, 12'h456, 0},
		'{0, 0, 1, 12'h800, 1, 12'h000, 0}};
	ssnl_prog_unit pu_u (
		.clk_i(clk), .ack_i(pack), .refused_i(pref), .rdata_i(prdat),
		.rd_o(prd), .wr_o(pwr), .addr_o(pa), .wdata_o(pwd));
	ssnl_loader dut_u (
		.clk_i(clk), .rstn_i(rstn), .uv_ok_i(uv), .prog_level_i(plev),
		.overvoltage_i(ov), .conv_valid_i(cv), .conv_is_temp_i(ct),
		.conv_over_i(co), .conv_under_i(cu), .conv_code_i(cc),
		.out_code_o(oc), .out_update_o(ou), .out_drive_o(od),
		.prog_rd_i(prd), .prog_wr_i(pwr), .prog_addr_i(pa), .prog_wdata_i(pwd),
		.prog_rdata_o(prdat), .prog_ack_o(pack), .prog_refused_o(pref),
		.oscillator_trim_o(t_osc), .current_source_balance_trim_o(t_bal),
		.reference_current_trim_o(t_ref), .plate_current_setting_o(t_pl),
		.first_order_temp_comp_o(t_tc), .running_o(run),
		.programming_mode_o(pm), .crc_fault_level_o(crcf),
		.clip_fault_level_o(clipf));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait for running (sel 0) or programming mode (sel 1)
	task automatic wait_hi(input logic sel, output int n);
		n = 0;
		while (((sel ? pm : run) !== 1'b1) && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 400) begin
			chk(16'h0000, 16'h0001);
			complete_run();
		end
	endtask
	task automatic conv(input ssnl_row_s r);
		@(posedge clk);
		cv <= 1'b1;
		ct <= r.temp;
		co <= r.over;
		cu <= r.under;
		cc <= r.code;
		@(posedge clk);
		cv <= 1'b0;
		// The update pulse stands only in the cycle right after the taking edge
		#1;
		chk(16'(ou), 16'(r.upd));
		if (r.upd)
			chk(16'(oc), 16'(r.exp));
		chk(16'(clipf), 16'(r.fault));
	endtask
	function automatic logic [9:0] crc_of();
		logic [9:0] c;
		logic fb;
		c = CRC_INIT;
		for (int a = 0; a < 27; a++)
			for (int b = 0; b < 5; b++) begin
				fb = c[9] ^ fld[a][b];
				c = {c[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
			end
		return c;
	endfunction
	task automatic write_all();
		logic [15:0] d, rd;
		logic rf, ok;
		logic [9:0] c;
		c = crc_of();
		fld[27] = c[4:0];
		fld[28] = c[9:5];
		for (int a = 0; a < 32; a++) begin
			d = (a < 29) ? {a == 0, fld[a], fld[a], fld[a]} : 16'h1234;
			// One disturbed copy must be outvoted
			if (a == 1)
				d = {1'b0, 5'h1F, 5'h0A, 5'h0A};
			pu_u.cmd(1'b1, 5'(a), d, rd, rf, ok);
			chk(16'(ok), 16'h0001);
			chk(16'(rf), 16'(a > 29));
		end
	endtask
	initial begin
		int n;
		logic [15:0] rd;
		logic rf, ok;
		{rstn, ov, cv, ct, co, cu} = 6'h00;
		{uv, plev} = 2'b11;
		cc = 12'h000;
		for (int a = 0; a < 29; a++)
			fld[a] = 5'h00;
		{fld[0], fld[1], fld[2], fld[3]} = {5'h15, 5'h0A, 5'h05, 5'h0C};
		{fld[4], fld[5], fld[6]} = {5'h13, 5'h02, 5'h01};
		repeat (8) @(posedge clk);
		#1;
		chk(16'(od), 16'h0000);
		chk(16'(run), 16'h0000);
		$display("test reset done");
		@(posedge clk);
		rstn <= 1'b1;
		wait_hi(1'b1, n);
		chk(16'(od), 16'h0000);
		write_all();
		pu_u.cmd(1'b1, 5'h00, 16'h0000, rd, rf, ok);
		chk(16'(rf), 16'h0001);
		pu_u.cmd(1'b0, 5'h00, 16'h0000, rd, rf, ok);
		chk(rd, 16'hD6B5);
		pu_u.cmd(1'b0, 5'h1D, 16'h0000, rd, rf, ok);
		chk(rd, 16'h1234);
		$display("test programming done");
		@(posedge clk);
		plev <= 1'b0;
		wait_hi(1'b0, n);
		chk(16'(t_osc), 16'h0015);
		chk(16'(t_bal), 16'h000A);
		chk(16'(t_ref), 16'h0005);
		chk(16'(t_pl), 16'h000C);
		chk(16'(t_tc), 16'h0053);
		$display("test load done");
		for (int i = 0; i < 8; i++)
			conv(rows[i]);
		chk(16'(od), 16'h0001);
		$display("test conversions done");
		@(posedge clk);
		uv <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(16'(od), 16'h0000);
		conv('{0, 0, 0, 12'h111, 0, 12'h000, 0});
		@(posedge clk);
		uv <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk(16'(od), 16'h0001);
		chk(16'(run), 16'h0001);
		$display("test undervoltage done");
		@(posedge clk);
		plev <= 1'b1;
		wait_hi(1'b1, n);
		pu_u.cmd(1'b1, 5'h06, 16'h0842, rd, rf, ok);
		chk(16'(rf), 16'h0000);
		@(posedge clk);
		plev <= 1'b0;
		wait_hi(1'b0, n);
		chk(16'(n >= 90), 16'h0001);
		chk(16'(crcf), 16'h0001);
		conv('{0, 0, 0, 12'h321, 1, 12'hFC0, 0});
		conv('{0, 0, 0, 12'h322, 1, 12'hFC0, 0});
		$display("test crc fault done");
		@(posedge clk);
		ov <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk(16'(od), 16'h0000);
		ov <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(16'(run), 16'h0000);
		wait_hi(1'b0, n);
		$display("test overvoltage done");
		complete_run();
	end
endmodule
`default_nettype wire
